// ### mts_defines.svh
// offsets, field positions, reset values and timing counts of the trigger sequencer
`ifndef MTS_DEFINES_SVH
`define MTS_DEFINES_SVH
`define MTS_OFF_CTRL 8'h00
`define MTS_OFF_CMD 8'h04
`define MTS_OFF_DELAY 8'h08
`define MTS_OFF_HOLD 8'h0c
`define MTS_OFF_CFG 8'h10
`define MTS_OFF_STAT 8'h14
`define MTS_OFF_ERR 8'h18
`define MTS_OFF_SETTLE 8'h1c
`define MTS_CTRL_SRC_LSB 0
`define MTS_CTRL_POL_BIT 3
`define MTS_CTRL_AUTO_LSB 4
`define MTS_CTRL_CONT_BIT 6
`define MTS_CMD_INIT_BIT 0
`define MTS_CMD_IMM_BIT 1
`define MTS_CMD_BUS_BIT 2
`define MTS_CMD_LOCAL_BIT 3
`define MTS_CMD_MEASCFG_BIT 4
`define MTS_CFG_DETAVG_BIT 8
`define MTS_CFG_AVGSNS_BIT 9
`define MTS_CFG_MASTER_BIT 10
`define MTS_CFG_SLAVE_BIT 11
`define MTS_STAT_CONFLICT_BIT 0
`define MTS_SPEED_CONFLICT 8'hc8
`define MTS_ERR_CONFLICT 32'hffffff23
`define MTS_CLK_NS 10
`define MTS_TICK_NS 50
`define MTS_TICK_CYC ((`MTS_TICK_NS + `MTS_CLK_NS - 1) / `MTS_CLK_NS)
`define MTS_DELAY_MAX_NS 1000000000
`define MTS_DELAY_MAX_TICKS (`MTS_DELAY_MAX_NS / `MTS_TICK_NS)
`define MTS_HOLD_MIN_NS 1000
`define MTS_HOLD_MAX_NS 400000000
`define MTS_HOLD_MIN_TICKS (`MTS_HOLD_MIN_NS / `MTS_TICK_NS)
`define MTS_HOLD_MAX_TICKS (`MTS_HOLD_MAX_NS / `MTS_TICK_NS)
`define MTS_SETTLE_RST 26'h0000064
`endif

// ### mts_pkg.sv
// types of the trigger sequencer
package mts_pkg;
  typedef enum logic [2:0] {
    MTS_SRC_BUS = 3'h0,
    MTS_SRC_EXT = 3'h1,
    MTS_SRC_HOLD = 3'h2,
    MTS_SRC_ALWAYS = 3'h3,
    MTS_SRC_INTERNAL_TRIGGER_ONE = 3'h4,
    MTS_SRC_INTERNAL_TRIGGER_TWO = 3'h5
  } mts_src_e;
  typedef enum logic [1:0] {
    MTS_SETTLE_OFF = 2'h0,
    MTS_SETTLE_ON = 2'h1,
    MTS_SETTLE_ONCE = 2'h2
  } mts_settle_e;
  typedef enum logic [2:0] {
    MTS_ST_IDLE = 3'h0,
    MTS_ST_WAIT = 3'h1,
    MTS_ST_DELAY = 3'h2,
    MTS_ST_SETTLE = 3'h3,
    MTS_ST_MEAS = 3'h4,
    MTS_ST_HOLD = 3'h5
  } mts_state_e;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } mts_apb_req_s;
  typedef logic [25:0] mts_ticks_t;
endpackage : mts_pkg

// ### mts_trigger_seq.sv
// trigger sequencer for one measurement channel with apb registers
// Notes on behaviour
// - measurement waits programmed delay after trigger, -1..1 s in 50 ns, reset 0
// - delay or holdoff change rejected with -221 unless external source selected
// - holdoff 1 us..0.4 s in 50 ns steps, reset 1 us
// - settling on: settle delay before requested and every later measurement
// - settling off: measure as soon as trigger arrives
// - settling once: settle delay before next measurement only
// - settling on after reset; readback 1 when on, 0 when off
// - settling ignored when the immediate override fires
// - immediate command while waiting: measure at once, skip delay, one time
// - bus source: group trigger, common trigger or immediate command
// - external source: rear trigger input or immediate command
// - suspended source: only the immediate command triggers
// - always-true source free runs when continuous, else one measurement
// - source selection never arms; only initiation or the continuous bit does
// - source forced always-true at reset, local mode, measure or configure
// - master choosing bus, suspended or always-true source while slave linked raises -221
// - internal or external source with speed 200 raises -221
// - internal source with average detector raises -221
// - internal source with average-only sensor raises -221
// - trigger on rising edge for rising_edge_polarity, falling for falling_edge_polarity; reset rising_edge_polarity
`include "mts_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module mts_trigger_seq
  import mts_pkg::*;
(
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire mts_apb_req_s apb_i,
  input wire logic ext_trig_i,
  input wire logic [1:0] int_trig_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic meas_start_o,
  output logic armed_o,
  output logic busy_o
);
  localparam logic [2:0] TICK_LAST = 3'(`MTS_TICK_CYC - 1);
  localparam mts_ticks_t DLY_MAX = 26'(`MTS_DELAY_MAX_TICKS);
  localparam mts_ticks_t HLD_MIN = 26'(`MTS_HOLD_MIN_TICKS);
  localparam mts_ticks_t HLD_MAX = 26'(`MTS_HOLD_MAX_TICKS);

  // edge recognition shared by external and internal inputs
  function automatic logic edge_hit(input logic falling, input logic prv,
                                    input logic cur);
    edge_hit = falling ? (prv & ~cur) : (~prv & cur);
  endfunction : edge_hit

  function automatic mts_ticks_t clamp(input mts_ticks_t v, input mts_ticks_t lo,
                                       input mts_ticks_t hi);
    if (v < lo) begin
      clamp = lo;
    end else if (v > hi) begin
      clamp = hi;
    end else begin
      clamp = v;
    end
  endfunction : clamp

  mts_src_e src_reg;
  mts_settle_e settle_mode_reg;
  mts_state_e state_reg;
  mts_state_e state_next;
  logic falling_reg;
  logic cont_reg;
  logic [26:0] delay_reg;
  mts_ticks_t hold_reg;
  mts_ticks_t settle_reg;
  logic [11:0] cfg_reg;
  logic conflict_reg;
  logic once_pending_reg;
  logic ready_reg;
  logic [2:0] pre_reg;
  mts_ticks_t tmr_reg;
  logic ext_prev_reg;
  logic [1:0] int_prev_reg;
  logic [31:0] rdata_reg;
  logic slverr_reg;
  logic meas_reg;
  logic armed_reg;
  logic busy_reg;

  // apb: pready rises in the second access cycle, one wait state always
  logic acc;
  logic wr_go;
  logic rd_go;
  logic [31:0] wd;
  logic [7:0] adr;
  assign acc = apb_i.psel & apb_i.penable & ready_reg;
  assign wr_go = acc & apb_i.pwrite;
  assign rd_go = acc & ~apb_i.pwrite;
  assign wd = apb_i.pwdata;
  assign adr = apb_i.paddr;

  logic mapped;
  always_comb begin
    case (adr)
      `MTS_OFF_CTRL, `MTS_OFF_CMD, `MTS_OFF_DELAY, `MTS_OFF_HOLD,
      `MTS_OFF_CFG, `MTS_OFF_STAT, `MTS_OFF_ERR, `MTS_OFF_SETTLE: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  logic cmd_wr;
  logic cmd_init;
  logic cmd_imm;
  logic cmd_bus;
  logic cmd_force;
  assign cmd_wr = wr_go & (adr == `MTS_OFF_CMD);
  assign cmd_init = cmd_wr & wd[`MTS_CMD_INIT_BIT];
  assign cmd_imm = cmd_wr & wd[`MTS_CMD_IMM_BIT];
  assign cmd_bus = cmd_wr & wd[`MTS_CMD_BUS_BIT];
  assign cmd_force = cmd_wr & (wd[`MTS_CMD_LOCAL_BIT] | wd[`MTS_CMD_MEASCFG_BIT]);

  // settings conflict checks on a source or timer write
  mts_src_e new_src;
  logic new_is_int;
  logic src_bad;
  logic tmr_bad;
  logic ctrl_wr;
  logic tmr_wr;
  assign ctrl_wr = wr_go & (adr == `MTS_OFF_CTRL);
  assign tmr_wr = wr_go & ((adr == `MTS_OFF_DELAY) | (adr == `MTS_OFF_HOLD));
  assign new_src = mts_src_e'(wd[`MTS_CTRL_SRC_LSB +: 3]);
  assign new_is_int = (new_src == MTS_SRC_INTERNAL_TRIGGER_ONE) | (new_src == MTS_SRC_INTERNAL_TRIGGER_TWO);
  always_comb begin
    src_bad = 1'b0;
    if (new_src > MTS_SRC_INTERNAL_TRIGGER_TWO) begin
      src_bad = 1'b1;
    end
    if (cfg_reg[`MTS_CFG_MASTER_BIT] & cfg_reg[`MTS_CFG_SLAVE_BIT]
        & ((new_src == MTS_SRC_BUS) | (new_src == MTS_SRC_HOLD)
           | (new_src == MTS_SRC_ALWAYS))) begin
      src_bad = 1'b1;
    end
    if ((new_is_int | (new_src == MTS_SRC_EXT))
        & (cfg_reg[7:0] == `MTS_SPEED_CONFLICT)) begin
      src_bad = 1'b1;
    end
    if (new_is_int & cfg_reg[`MTS_CFG_DETAVG_BIT]) begin
      src_bad = 1'b1;
    end
    if (new_is_int & cfg_reg[`MTS_CFG_AVGSNS_BIT]) begin
      src_bad = 1'b1;
    end
  end
  assign tmr_bad = src_reg != MTS_SRC_EXT;

  logic reject;
  assign reject = (ctrl_wr & src_bad) | (tmr_wr & tmr_bad);

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ready_reg <= 1'b0;
      slverr_reg <= 1'b0;
    end else begin
      ready_reg <= apb_i.psel & apb_i.penable & ~ready_reg;
      slverr_reg <= apb_i.psel & apb_i.penable & ~ready_reg
                    & (~mapped | ((adr == `MTS_OFF_CTRL) & apb_i.pwrite & src_bad)
                       | (apb_i.pwrite & tmr_bad
                          & ((adr == `MTS_OFF_DELAY) | (adr == `MTS_OFF_HOLD))));
    end
  end

  // source: forced to always-true on reset and by local/measure/configure
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      src_reg <= MTS_SRC_ALWAYS;
    end else if (cmd_force) begin
      src_reg <= MTS_SRC_ALWAYS;
    end else if (ctrl_wr & ~src_bad) begin
      src_reg <= new_src;
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      falling_reg <= 1'b0;
      cont_reg <= 1'b0;
      settle_mode_reg <= MTS_SETTLE_ON;
    end else if (ctrl_wr) begin
      falling_reg <= wd[`MTS_CTRL_POL_BIT];
      cont_reg <= wd[`MTS_CTRL_CONT_BIT];
      settle_mode_reg <= (wd[`MTS_CTRL_AUTO_LSB +: 2] == 2'h3) ? MTS_SETTLE_OFF
                         : mts_settle_e'(wd[`MTS_CTRL_AUTO_LSB +: 2]);
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      delay_reg <= 27'h0;
      hold_reg <= HLD_MIN;
      settle_reg <= `MTS_SETTLE_RST;
      cfg_reg <= 12'h0;
    end else if (wr_go & ~reject) begin
      case (adr)
        `MTS_OFF_DELAY: begin
          if (wd[31]) begin
            delay_reg <= {1'b1, ~clamp(~wd[25:0], 26'h0, DLY_MAX - 26'h1)};
          end else begin
            delay_reg <= {1'b0, clamp(wd[25:0], 26'h0, DLY_MAX)};
          end
        end
        `MTS_OFF_HOLD: hold_reg <= clamp(wd[25:0], HLD_MIN, HLD_MAX);
        `MTS_OFF_CFG: cfg_reg <= wd[11:0];
        `MTS_OFF_SETTLE: settle_reg <= wd[25:0];
        default: ;
      endcase
    end
  end

  // a rejection in the same cycle as a clear keeps the flag set
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      conflict_reg <= 1'b0;
    end else if (reject) begin
      conflict_reg <= 1'b1;
    end else if (wr_go & (adr == `MTS_OFF_STAT) & wd[`MTS_STAT_CONFLICT_BIT]) begin
      conflict_reg <= 1'b0;
    end
  end

  // trigger recognition per source
  logic ext_hit;
  logic int_hit;
  logic trig_ev;
  assign ext_hit = edge_hit(falling_reg, ext_prev_reg, ext_trig_i);
  assign int_hit = (src_reg == MTS_SRC_INTERNAL_TRIGGER_ONE)
                   ? edge_hit(falling_reg, int_prev_reg[0], int_trig_i[0])
                   : edge_hit(falling_reg, int_prev_reg[1], int_trig_i[1]);
  always_comb begin
    case (src_reg)
      MTS_SRC_BUS: trig_ev = cmd_bus;
      MTS_SRC_EXT: trig_ev = ext_hit;
      MTS_SRC_HOLD: trig_ev = 1'b0;
      MTS_SRC_ALWAYS: trig_ev = 1'b1;
      MTS_SRC_INTERNAL_TRIGGER_ONE, MTS_SRC_INTERNAL_TRIGGER_TWO: trig_ev = int_hit;
      default: trig_ev = 1'b0;
    endcase
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ext_prev_reg <= 1'b0;
      int_prev_reg <= 2'h0;
    end else begin
      ext_prev_reg <= ext_trig_i;
      int_prev_reg <= int_trig_i;
    end
  end

  // 50 ns tick prescaler, restarted when a timer is loaded
  logic tick;
  logic load;
  assign tick = pre_reg == TICK_LAST;
  assign load = state_next != state_reg;

  logic settle_due;
  logic dly_zero;
  assign settle_due = (settle_mode_reg == MTS_SETTLE_ON) | once_pending_reg;
  assign dly_zero = delay_reg[26] | (delay_reg[25:0] == 26'h0);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      MTS_ST_IDLE: begin
        if (cmd_init | cont_reg) begin
          state_next = MTS_ST_WAIT;
        end
      end
      MTS_ST_WAIT: begin
        if (cmd_imm) begin
          state_next = MTS_ST_MEAS;
        end else if (trig_ev) begin
          if (!dly_zero) begin
            state_next = MTS_ST_DELAY;
          end else if (settle_due) begin
            state_next = MTS_ST_SETTLE;
          end else begin
            state_next = MTS_ST_MEAS;
          end
        end
      end
      MTS_ST_DELAY: begin
        if (tick & (tmr_reg == 26'h1)) begin
          state_next = settle_due ? MTS_ST_SETTLE : MTS_ST_MEAS;
        end
      end
      MTS_ST_SETTLE: begin
        if ((settle_reg == 26'h0) | (tick & (tmr_reg == 26'h1))) begin
          state_next = MTS_ST_MEAS;
        end
      end
      MTS_ST_MEAS: state_next = MTS_ST_HOLD;
      MTS_ST_HOLD: begin
        if (tick & (tmr_reg == 26'h1)) begin
          state_next = cont_reg ? MTS_ST_WAIT : MTS_ST_IDLE;
        end
      end
      default: state_next = MTS_ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_reg <= MTS_ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // timers count ticks and are loaded as each timed state is entered
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pre_reg <= 3'h0;
      tmr_reg <= 26'h0;
    end else if (load) begin
      pre_reg <= 3'h0;
      case (state_next)
        MTS_ST_DELAY: tmr_reg <= delay_reg[25:0];
        MTS_ST_SETTLE: tmr_reg <= settle_reg;
        MTS_ST_HOLD: tmr_reg <= hold_reg;
        default: tmr_reg <= 26'h0;
      endcase
    end else begin
      pre_reg <= tick ? 3'h0 : pre_reg + 3'h1;
      if (tick & (tmr_reg != 26'h0)) begin
        tmr_reg <= tmr_reg - 26'h1;
      end
    end
  end

  // once: armed by writing the once option, spent by the next settle
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      once_pending_reg <= 1'b0;
    end else if (ctrl_wr) begin
      once_pending_reg <= wd[`MTS_CTRL_AUTO_LSB +: 2] == 2'h2;
    end else if ((state_reg == MTS_ST_SETTLE) & (state_next == MTS_ST_MEAS)) begin
      once_pending_reg <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meas_reg <= 1'b0;
      armed_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      meas_reg <= state_next == MTS_ST_MEAS;
      armed_reg <= state_next == MTS_ST_WAIT;
      busy_reg <= (state_next != MTS_ST_IDLE) & (state_next != MTS_ST_WAIT);
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_reg <= 32'h0;
    end else if (apb_i.psel & apb_i.penable & ~ready_reg & ~apb_i.pwrite) begin
      case (adr)
        `MTS_OFF_CTRL: rdata_reg <= {25'h0, cont_reg,
                                     (settle_mode_reg == MTS_SETTLE_ON) ? 2'h1 : 2'h0,
                                     falling_reg, src_reg};
        `MTS_OFF_DELAY: rdata_reg <= {{5{delay_reg[26]}}, delay_reg};
        `MTS_OFF_HOLD: rdata_reg <= {6'h0, hold_reg};
        `MTS_OFF_CFG: rdata_reg <= {20'h0, cfg_reg};
        `MTS_OFF_STAT: rdata_reg <= {24'h0, state_reg, 2'h0, once_pending_reg,
                                     settle_mode_reg == MTS_SETTLE_ON, conflict_reg};
        `MTS_OFF_ERR: rdata_reg <= conflict_reg ? `MTS_ERR_CONFLICT : 32'h0;
        `MTS_OFF_SETTLE: rdata_reg <= {6'h0, settle_reg};
        default: rdata_reg <= 32'h0;
      endcase
    end
  end

  assign prdata_o = rdata_reg;
  assign pready_o = ready_reg;
  assign pslverr_o = slverr_reg;
  assign meas_start_o = meas_reg;
  assign armed_o = armed_reg;
  assign busy_o = busy_reg;

  default clocking @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);

  sequence s_imm_wait;
    (state_reg == MTS_ST_WAIT) ##0 cmd_imm;
  endsequence

  a_imm_skips_delay: assert property (s_imm_wait |=> (state_reg == MTS_ST_MEAS) && meas_reg)
    else $error("immediate override did not measure at once");
  a_tmr_reject: assert property (tmr_wr & tmr_bad |=> conflict_reg & $stable(hold_reg))
    else $error("timer write accepted without external source");
  a_force_src: assert property (cmd_force |=> src_reg == MTS_SRC_ALWAYS)
    else $error("source not forced to always-true");
  a_src_no_arm: assert property ((state_reg == MTS_ST_IDLE) & ctrl_wr & ~cmd_init & ~cont_reg
                                 & ~wd[`MTS_CTRL_CONT_BIT] |=> state_reg == MTS_ST_IDLE)
    else $error("source write armed the sequencer");
  a_hold_bounds: assert property (hold_reg >= HLD_MIN && hold_reg <= HLD_MAX)
    else $error("holdoff outside range");
  a_settle_off: assert property ((state_reg == MTS_ST_WAIT) & trig_ev & dly_zero & ~settle_due
                                 & ~cmd_imm |=> state_reg == MTS_ST_MEAS)
    else $error("settling inserted while off");
  a_susp_ignore: assert property ((src_reg == MTS_SRC_HOLD) & (state_reg == MTS_ST_WAIT)
                                  & ~cmd_imm |=> state_reg == MTS_ST_WAIT)
    else $error("suspended source triggered");
  a_speed_conf: assert property (ctrl_wr & (new_src == MTS_SRC_EXT) & (src_reg != MTS_SRC_EXT)
                                 & (cfg_reg[7:0] == `MTS_SPEED_CONFLICT) & ~cmd_force
                                 |=> conflict_reg & (src_reg != MTS_SRC_EXT))
    else $error("speed conflict not raised");
  a_ext_edge: assert property ((src_reg == MTS_SRC_EXT) & (state_reg == MTS_ST_WAIT) & ~cmd_imm
                               & ~ext_hit |=> state_reg == MTS_ST_WAIT)
    else $error("external source fired without edge");
  a_once_spent: assert property ((state_reg == MTS_ST_SETTLE) & (state_next == MTS_ST_MEAS)
                                 & ~ctrl_wr |=> ~once_pending_reg)
    else $error("once settling not spent");
endmodule : mts_trigger_seq
`default_nettype wire

// ### mts_trig_partner.sv
// far-side model of the rear trigger line and the internal trigger lines
`timescale 1ns/1ps
`default_nettype none
module mts_trig_partner (
  input wire logic mclk_i,
  output logic ext_trig_o,
  output logic [1:0] int_trig_o
);
  initial begin
    ext_trig_o = 1'b0;
    int_trig_o = 2'h0;
  end
  // each level is held three cycles so the device sees every edge apart
  task automatic pulse(input logic lvl);
    @(posedge mclk_i);
    ext_trig_o <= lvl;
    repeat (3) @(posedge mclk_i);
    ext_trig_o <= ~lvl;
    repeat (3) @(posedge mclk_i);
  endtask : pulse
  task automatic set_idle(input logic lvl);
    @(posedge mclk_i);
    ext_trig_o <= lvl;
    repeat (3) @(posedge mclk_i);
  endtask : set_idle
  // rising then falling level on the internal lines picked by sel
  task automatic int_pulse(input logic [1:0] sel);
    @(posedge mclk_i);
    int_trig_o <= sel;
    repeat (3) @(posedge mclk_i);
    int_trig_o <= 2'h0;
    repeat (3) @(posedge mclk_i);
  endtask : int_pulse
endmodule : mts_trig_partner
`default_nettype wire

// ### mts_trigger_seq_tb.sv
// self-checking testbench of the trigger sequencer
`include "mts_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module mts_trigger_seq_tb
  import mts_pkg::*;
;
  logic mclk_i = 1'b0;
  logic arst_n_i = 1'b0;
  mts_apb_req_s apb_req = '0;
  logic ext_trig;
  logic [1:0] int_trig;
  logic [31:0] prdata_o;
  logic pready_o, pslverr_o, meas_start_o, armed_o, busy_o;
  int mismatches = 0;
  int total_checks = 0;
  int cyc = 0;
  int meas_cnt = 0;
  int last_meas = 0;

  always #5 mclk_i = ~mclk_i;

  mts_trigger_seq i_dut (
    .mclk_i(mclk_i), .arst_n_i(arst_n_i), .apb_i(apb_req), .ext_trig_i(ext_trig),
    .int_trig_i(int_trig), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .meas_start_o(meas_start_o), .armed_o(armed_o),
    .busy_o(busy_o)
  );
  mts_trig_partner u_far (.mclk_i(mclk_i), .ext_trig_o(ext_trig), .int_trig_o(int_trig));

  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (meas_start_o === 1'b1) begin
      meas_cnt <= meas_cnt + 1;
      last_meas <= cyc;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // request held until the rising edge where pready is sampled high; answer taken there
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rdat, output logic err);
    int n;
    @(posedge mclk_i);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge mclk_i);
    apb_req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 50);
    if (n >= 50) mismatches++;
    rdat = prdata_o;
    err = pslverr_o;
    apb_req <= '0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
    logic [31:0] r;
    logic er;
    apb(1'b1, a, d, r, er);
    chk({31'h0, er}, {31'h0, e});
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic er;
    apb(1'b0, a, 32'h0, r, er);
    chk(r, exp);
  endtask : rd

  task automatic quiet_chk(input int n, input int m0, input int exp);
    repeat (n) @(posedge mclk_i);
    chk(32'(meas_cnt - m0), 32'(exp));
  endtask : quiet_chk

  // latency from a rising pulse on the rear line to the measurement start
  task automatic lat(output int l);
    int c0, m0;
    c0 = cyc;
    m0 = meas_cnt;
    u_far.pulse(1'b1);
    quiet_chk(200, m0, 1);
    l = last_meas - c0;
  endtask : lat

  task automatic per(output int p);
    int m, t;
    repeat (20) @(posedge mclk_i);
    m = meas_cnt;
    for (int i = 0; i < 600 && meas_cnt < m + 1; i++) @(posedge mclk_i);
    t = last_meas;
    for (int i = 0; i < 600 && meas_cnt < m + 2; i++) @(posedge mclk_i);
    p = last_meas - t;
  endtask : per

  task automatic t_reset;
    rd(`MTS_OFF_CTRL, 32'h13);
    rd(`MTS_OFF_DELAY, 32'h0);
    rd(`MTS_OFF_HOLD, 32'h14);
    rd(`MTS_OFF_ERR, 32'h0);
    chk({31'h0, armed_o}, 32'h0);
    rd(8'h40, 32'h0);
    chk({31'h0, busy_o}, 32'h0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_reject;
    wr(`MTS_OFF_DELAY, 32'h5, 1'b1);
    wr(`MTS_OFF_HOLD, 32'h30, 1'b1);
    rd(`MTS_OFF_DELAY, 32'h0);
    rd(`MTS_OFF_ERR, `MTS_ERR_CONFLICT);
    wr(`MTS_OFF_STAT, 32'h1, 1'b0);
    rd(`MTS_OFF_ERR, 32'h0);
    $display("test reject done");
  endtask : t_reject

  task automatic t_ext;
    int m0;
    wr(`MTS_OFF_CTRL, 32'h01, 1'b0);
    chk({31'h0, armed_o}, 32'h0);
    wr(`MTS_OFF_CMD, 32'h1, 1'b0);
    @(posedge mclk_i);
    chk({31'h0, armed_o}, 32'h1);
    m0 = meas_cnt;
    wr(`MTS_OFF_CMD, 32'h4, 1'b0);
    quiet_chk(30, m0, 0);
    u_far.pulse(1'b1);
    quiet_chk(200, m0, 1);
    wr(`MTS_OFF_CTRL, 32'h09, 1'b0);
    wr(`MTS_OFF_CMD, 32'h1, 1'b0);
    u_far.set_idle(1'b1);
    quiet_chk(30, m0, 1);
    u_far.pulse(1'b0);
    quiet_chk(200, m0, 2);
    u_far.set_idle(1'b0);
    $display("test external done");
  endtask : t_ext

  task automatic t_settle;
    int l0, l1;
    wr(`MTS_OFF_SETTLE, 32'h4, 1'b0);
    wr(`MTS_OFF_CTRL, 32'h41, 1'b0);
    lat(l0);
    wr(`MTS_OFF_CTRL, 32'h51, 1'b0);
    lat(l1);
    chk(32'(l1 - l0), 32'd20);
    lat(l1);
    chk(32'(l1 - l0), 32'd20);
    wr(`MTS_OFF_CTRL, 32'h61, 1'b0);
    rd(`MTS_OFF_CTRL, 32'h41);
    lat(l1);
    chk(32'(l1 - l0), 32'd20);
    lat(l1);
    chk(32'(l1 - l0), 32'd0);
    wr(`MTS_OFF_DELAY, 32'h6, 1'b0);
    lat(l1);
    chk({31'h0, l1 - l0 >= 25 && l1 - l0 <= 35}, 32'h1);
    wr(`MTS_OFF_DELAY, 32'h0, 1'b0);
    $display("test settle done");
  endtask : t_settle

  task automatic t_run;
    int p1, p2, m0;
    wr(`MTS_OFF_CTRL, 32'h43, 1'b0);
    per(p1);
    wr(`MTS_OFF_CTRL, 32'h01, 1'b0);
    wr(`MTS_OFF_HOLD, 32'h28, 1'b0);
    wr(`MTS_OFF_CTRL, 32'h43, 1'b0);
    per(p2);
    chk(32'(p2 - p1), 32'd100);
    wr(`MTS_OFF_CTRL, 32'h03, 1'b0);
    repeat (300) @(posedge mclk_i);
    m0 = meas_cnt;
    wr(`MTS_OFF_CMD, 32'h1, 1'b0);
    quiet_chk(400, m0, 1);
    $display("test free run done");
  endtask : t_run

  task automatic t_imm;
    int m0;
    wr(`MTS_OFF_CTRL, 32'h12, 1'b0);
    wr(`MTS_OFF_CMD, 32'h1, 1'b0);
    m0 = meas_cnt;
    u_far.pulse(1'b1);
    wr(`MTS_OFF_CMD, 32'h4, 1'b0);
    quiet_chk(30, m0, 0);
    wr(`MTS_OFF_CMD, 32'h2, 1'b0);
    quiet_chk(5, m0, 1);
    chk({31'h0, busy_o}, 32'h1);
    // host issues no read query while this source is selected
    wr(`MTS_OFF_CTRL, 32'h00, 1'b0);
    repeat (200) @(posedge mclk_i);
    wr(`MTS_OFF_CMD, 32'h1, 1'b0);
    wr(`MTS_OFF_CMD, 32'h4, 1'b0);
    quiet_chk(10, m0, 2);
    repeat (200) @(posedge mclk_i);
    wr(`MTS_OFF_CMD, 32'h1, 1'b0);
    wr(`MTS_OFF_CMD, 32'h2, 1'b0);
    quiet_chk(10, m0, 3);
    $display("test immediate done");
  endtask : t_imm

  task automatic t_conflict;
    repeat (200) @(posedge mclk_i);
    wr(`MTS_OFF_CFG, 32'hc8, 1'b0);
    wr(`MTS_OFF_CTRL, 32'h01, 1'b1);
    wr(`MTS_OFF_CTRL, 32'h04, 1'b1);
    wr(`MTS_OFF_CFG, 32'h100, 1'b0);
    wr(`MTS_OFF_CTRL, 32'h04, 1'b1);
    wr(`MTS_OFF_CFG, 32'h200, 1'b0);
    wr(`MTS_OFF_CTRL, 32'h05, 1'b1);
    wr(`MTS_OFF_CFG, 32'h0, 1'b0);
    wr(`MTS_OFF_CTRL, 32'h01, 1'b0);
    wr(`MTS_OFF_CFG, 32'hc00, 1'b0);
    wr(`MTS_OFF_CTRL, 32'h00, 1'b1);
    rd(`MTS_OFF_CTRL, 32'h01);
    wr(`MTS_OFF_CFG, 32'h0, 1'b0);
    wr(`MTS_OFF_CMD, 32'h8, 1'b0);
    rd(`MTS_OFF_CTRL, 32'h03);
    wr(`MTS_OFF_CTRL, 32'h01, 1'b0);
    wr(`MTS_OFF_CMD, 32'h10, 1'b0);
    rd(`MTS_OFF_CTRL, 32'h03);
    $display("test conflict done");
  endtask : t_conflict

  // internal line 1 is ignored while line 0 is the selected source; each line fires when it is selected
  task automatic t_int;
    int m0;
    wr(`MTS_OFF_CTRL, 32'h04, 1'b0);
    wr(`MTS_OFF_CMD, 32'h1, 1'b0);
    m0 = meas_cnt;
    u_far.int_pulse(2'h2);
    quiet_chk(30, m0, 0);
    u_far.int_pulse(2'h1);
    quiet_chk(200, m0, 1);
    wr(`MTS_OFF_CTRL, 32'h05, 1'b0);
    wr(`MTS_OFF_CMD, 32'h1, 1'b0);
    u_far.int_pulse(2'h2);
    quiet_chk(200, m0, 2);
    $display("test internal done");
  endtask : t_int

  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : finish_test

  initial begin
    repeat (16) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    t_reset();
    t_reject();
    t_ext();
    t_settle();
    t_run();
    t_imm();
    t_conflict();
    t_int();
    finish_test();
  end

  // the whole sequence needs well under 20,000 cycles
  initial begin
    #400us;
    mismatches++;
    finish_test();
  end
endmodule : mts_trigger_seq_tb
`default_nettype wire
